// *** include/cbs_pkg.sv ***
package cbs_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned PWR_CHECK_MS = 800;
  localparam int unsigned FORCED_OFF_S = 30;
  localparam longint unsigned PWR_CHECK_CYC = longint'(CLK_HZ) / 1000 * PWR_CHECK_MS;
  localparam longint unsigned FORCED_OFF_CYC = longint'(CLK_HZ) * FORCED_OFF_S;
  localparam int unsigned TMR_W = 32;

  // ----------------------------------------------------------------
  // Alarm codes reported by the supply unit
  // ----------------------------------------------------------------
  localparam logic [7:0] ALM_NONE = 8'h00;
  localparam logic [7:0] ALM_ESTOP_ERR = 8'h55;
  localparam logic [7:0] ALM_OPEN_PHASE = 8'h67;
  localparam logic [7:0] ALM_GND_FAULT = 8'h69;
  localparam logic [7:0] ALM_WELDED = 8'h6a;
  localparam logic [7:0] ALM_MAIN_CIRC = 8'h6c;

  localparam int unsigned NUM_PHASES = 3;

endpackage : cbs_pkg

// *** include/drive_link_if.sv ***
`timescale 1ns/1ps
// Link between the controller and the supply/servo unit
interface drive_link_if;
  logic ready_on;      // Controller requests main power on
  logic estop;         // Emergency stop (controller or servo alarm)
  logic servo_off;     // Servo-off command from controller sequence
  logic shutoff_cmd;   // Contactor shutoff command, relayed via drive unit
  logic zero_speed;    // All axes stopped or dynamic brake active
  logic motor_on;      // Motor producing torque
  logic contactor_on;  // Contactor drive output state
  logic alarm;         // Any supply alarm latched

  modport supply(input ready_on, estop, servo_off, shutoff_cmd,
                 output zero_speed, motor_on, contactor_on, alarm);
  modport ctrl(output ready_on, estop, servo_off, shutoff_cmd,
               input zero_speed, motor_on, contactor_on, alarm);
endinterface : drive_link_if

// *** hw/cbs_timer.sv ***
`timescale 1ns/1ps
// Down-counting one-shot: load on start, done pulses when it reaches zero
module cbs_timer #(
  parameter int unsigned W = 32
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic start_i,
  input wire logic abort_i,
  input wire logic [W-1:0] load_i,
  output logic done_o,
  output logic busy_o
);
  typedef struct packed {
    logic [W-1:0] cnt;
    logic done;
  } tmr_s;
  tmr_s q, d;

  // ----------------------------------------------------------------
  // Counter
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.done = 1'b0;
    if (abort_i) begin
      d.cnt = '0;
    end else if (start_i) begin
      d.cnt = load_i;
    end else if (q.cnt != '0) begin
      d.cnt = q.cnt - 1'b1;
      d.done = (q.cnt == {{(W-1){1'b0}}, 1'b1});
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign done_o = q.done;
  assign busy_o = (q.cnt != '0);
endmodule : cbs_timer

// *** hw/supply_unit.sv ***
`timescale 1ns/1ps
// Operation
// - Phase voltage before closing means welded
// - Check power about 800 ms after closing
// - Low voltage: main-circuit or open-phase alarm
// - Other check failure: ground-fault alarm
// - Controller confirms zero speed before shutoff
// - Shutoff command relayed, contactor output drops
// - No shutoff in 30 s: force off
// - Keep supply active while axes decelerate
// - Estop: decelerate or dynamic-brake the motor
// - Supply lost while decelerating: undervoltage
// - Contactor only driven by supply unit
// - Supply type configured before contactor use
// - Release brake only while motor on
// - Servo-off: brake with power removal, no drop-hold
// - Drop prevention only on emergency stops
// - External circuit applies brakes with estop; external_estop_signal_o is raised only on forced shutoff, not on every estop
// - Forced shutoff records estop error alarm
module supply_unit
  import cbs_pkg::*;
#(
  parameter longint unsigned CHECK_CYC = PWR_CHECK_CYC,
  parameter longint unsigned FORCE_CYC = FORCED_OFF_CYC
) (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  drive_link_if.supply link,
  input wire logic [NUM_PHASES-1:0] mains_phase_inputs_i,
  input wire logic supply_type_param_i,
  input wire logic dc_bus_ok_i,
  input wire logic motor_stopped_i,
  output logic contactor_drive_out_o,
  output logic external_estop_signal_o,
  output logic brake_release_out_o,
  output logic decel_active_o,
  output logic drop_prevent_o,
  output logic undervoltage_o,
  output logic [7:0] alarm_code_o
);
  typedef enum logic [2:0] {ST_OFF, ST_PRECHECK, ST_WAIT, ST_ON, ST_ESTOP, ST_ALARM} st_e;

  typedef struct packed {
    st_e st;
    logic [NUM_PHASES-1:0] ph_m;
    logic [NUM_PHASES-1:0] ph_s;
    logic [2:0] ctl_m;
    logic [2:0] ctl_s;
    logic mc;
    logic external_estop_signal;
    logic brake_rel;
    logic decel;
    logic drop;
    logic uv;
    logic motor_on;
    logic zero;
    logic [7:0] alarm;
  } sup_s;
  sup_s q, d;

  logic chk_done, frc_done, frc_busy;
  logic chk_start, frc_start, frc_abort;
  logic phase_any, phase_all;

  // ----------------------------------------------------------------
  // Timers
  // ----------------------------------------------------------------
  cbs_timer #(.W(TMR_W)) u_chk (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(chk_start),
    .abort_i(q.st != ST_WAIT && !chk_start),
    .load_i(TMR_W'(CHECK_CYC)),
    .done_o(chk_done),
    .busy_o()
  );

  cbs_timer #(.W(TMR_W)) u_frc (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .start_i(frc_start),
    .abort_i(frc_abort),
    .load_i(TMR_W'(FORCE_CYC)),
    .done_o(frc_done),
    .busy_o(frc_busy)
  );

  assign phase_any = |q.ph_s;
  assign phase_all = &q.ph_s;
  // Control pins synchronised: ready_on, estop, servo_off
  assign chk_start = (q.st == ST_PRECHECK) && !phase_any;
  assign frc_start = (q.st == ST_ON || q.st == ST_WAIT) && q.ctl_s[1];
  assign frc_abort = link.shutoff_cmd && frc_busy;

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ph_m = mains_phase_inputs_i;
    d.ph_s = q.ph_m;
    d.ctl_m = {link.servo_off, link.estop, link.ready_on};
    d.ctl_s = q.ctl_m;
    d.uv = 1'b0;
    case (q.st)
      ST_OFF: begin
        d.mc = 1'b0;
        // Without the supply type set the contactor stays open
        if (q.ctl_s[0] && !q.ctl_s[1] && supply_type_param_i) begin
          d.st = ST_PRECHECK;
        end
      end
      ST_PRECHECK: begin
        if (phase_any) begin
          d.alarm = ALM_WELDED;
          d.st = ST_ALARM;
        end else begin
          d.mc = 1'b1;
          d.st = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (chk_done) begin
          if (phase_all && dc_bus_ok_i) begin
            d.st = ST_ON;
          end else if (!phase_any) begin
            d.alarm = ALM_MAIN_CIRC;
            d.st = ST_ALARM;
          end else if (!phase_all) begin
            d.alarm = ALM_OPEN_PHASE;
            d.st = ST_ALARM;
          end else begin
            d.alarm = ALM_GND_FAULT;
            d.st = ST_ALARM;
          end
        end else if (q.ctl_s[1]) begin
          d.st = ST_ESTOP;
        end
      end
      ST_ON: begin
        if (q.ctl_s[1]) begin
          d.st = ST_ESTOP;
        end else if (link.shutoff_cmd || !q.ctl_s[0]) begin
          d.mc = 1'b0;
          d.st = ST_OFF;
        end
      end
      ST_ESTOP: begin
        // Contactor held closed so regenerated energy has a path
        if (link.shutoff_cmd) begin
          d.mc = 1'b0;
          d.st = ST_OFF;
        end else if (frc_done) begin
          d.mc = 1'b0;
          d.external_estop_signal = 1'b1;
          d.alarm = ALM_ESTOP_ERR;
          d.st = ST_ALARM;
        end
      end
      ST_ALARM: begin
        d.mc = 1'b0;
        if (!q.ctl_s[0] && !q.ctl_s[1]) begin
          d.alarm = ALM_NONE;
          d.external_estop_signal = 1'b0;
          d.st = ST_OFF;
        end
      end
      default: begin
        d.st = ST_OFF;
      end
    endcase

    // Servo side: motor on only with power and no stop request
    d.motor_on = (q.st == ST_ON) && !q.ctl_s[2] && !q.ctl_s[1];
    // Brake releases one cycle after motor_on rises but applies as it falls, so release lags power-on
    d.brake_rel = q.motor_on && d.motor_on;
    d.decel = q.ctl_s[1] && !motor_stopped_i;
    d.drop = q.ctl_s[1] && !motor_stopped_i && !q.ctl_s[2];
    if (q.decel && !q.mc) begin
      d.uv = 1'b1;
    end
    // Zero speed is only reported from the stop state; an idle value would let
    // the controller cut the contactor before the stop has reached this end
    d.zero = (d.st == ST_ESTOP) && !d.decel;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign contactor_drive_out_o = q.mc;
  assign external_estop_signal_o = q.external_estop_signal;
  assign brake_release_out_o = q.brake_rel;
  assign decel_active_o = q.decel;
  assign drop_prevent_o = q.drop;
  assign undervoltage_o = q.uv;
  assign alarm_code_o = q.alarm;
  assign link.zero_speed = q.zero;
  assign link.motor_on = q.motor_on;
  assign link.contactor_on = q.mc;
  assign link.alarm = (q.alarm != ALM_NONE);
endmodule : supply_unit

// *** hw/nc_controller.sv ***
`timescale 1ns/1ps
// Controller end: relays user requests, issues shutoff after zero speed
module nc_controller
  import cbs_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  drive_link_if.ctrl link,
  input wire logic power_req_i,
  input wire logic estop_req_i,
  input wire logic servo_off_req_i,
  output logic contactor_on_o,
  output logic motor_on_o,
  output logic alarm_o
);
  typedef struct packed {
    logic ready_on;
    logic estop;
    logic servo_off;
    logic shutoff;
    logic [2:0] st_m;
    logic [2:0] st_s;
  } nc_s;
  nc_s q, d;

  // ----------------------------------------------------------------
  // Command logic
  // ----------------------------------------------------------------
  always_comb begin
    d = q;
    d.ready_on = power_req_i;
    d.estop = estop_req_i;
    d.servo_off = servo_off_req_i;
    d.st_m = {link.alarm, link.motor_on, link.contactor_on};
    d.st_s = q.st_m;
    // Shutoff only once every axis reports zero speed
    d.shutoff = q.estop && link.zero_speed && q.st_s[0] && !q.shutoff;
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign link.ready_on = q.ready_on;
  assign link.estop = q.estop;
  assign link.servo_off = q.servo_off;
  assign link.shutoff_cmd = q.shutoff;
  assign contactor_on_o = q.st_s[0];
  assign motor_on_o = q.st_s[1];
  assign alarm_o = q.st_s[2];
endmodule : nc_controller

// *** testbench/link_check_sva.sv ***
`timescale 1ns/1ps
// Watches the drive link between the controller and the supply end
module link_check (
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  input wire logic ready_on,
  input wire logic estop,
  input wire logic servo_off,
  input wire logic shutoff_cmd,
  input wire logic zero_speed,
  input wire logic motor_on,
  input wire logic contactor_on,
  input wire logic alarm
);
  // --------------------------------------------------------------
  // Sequencing properties
  // --------------------------------------------------------------
  // One clock domain, so clock and reset are given once
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rstn_i);

  a_shutoff_after_stop: assert property (shutoff_cmd |-> zero_speed && estop)
    else $error("shutoff sent before zero speed");
  a_shutoff_opens: assert property (shutoff_cmd |-> ##[1:3] !contactor_on)
    else $error("contactor held after shutoff");
  a_shutoff_pulse: assert property (shutoff_cmd |=> !shutoff_cmd)
    else $error("shutoff not a single pulse");
  // Only a shutoff may open the contactor while axes still turn
  a_decel_keeps_on: assert property (contactor_on && estop && ready_on && !zero_speed
    && !shutoff_cmd |=> contactor_on)
    else $error("contactor opened during deceleration");
  a_close_clean: assert property ($rose(contactor_on) |-> ready_on && !estop && !alarm)
    else $error("contactor closed without clean request");
  a_check_delay: assert property ($rose(contactor_on) |=> !motor_on [*8])
    else $error("power check came too early");
  a_alarm_opens: assert property ($rose(alarm) |-> ##[0:3] !contactor_on)
    else $error("contactor held after alarm");
  a_motor_on_power: assert property ($rose(motor_on) |-> contactor_on && !estop)
    else $error("motor on without main power");
  a_servo_off_drop: assert property ($rose(servo_off) |-> ##[1:6] !motor_on)
    else $error("motor kept on after servo off");

  c_close: cover property ($rose(contactor_on));
  c_shutoff: cover property (shutoff_cmd);
  c_alarm: cover property ($rose(alarm));
  c_servo_off: cover property ($fell(motor_on) && servo_off);
endmodule : link_check

// *** testbench/tb.sv ***
`timescale 1ns/1ps
module tb import cbs_pkg::*; ;
  // --------------------------------------------------------------
  // Clock, stimulus and the two link pairs
  // --------------------------------------------------------------
  localparam logic [2:0] WL [4] = '{3'b111, 3'b000, 3'b000, 3'b000};
  localparam logic [2:0] PT [4] = '{3'b111, 3'b000, 3'b011, 3'b111};
  localparam logic DC [4] = '{1'b1, 1'b1, 1'b1, 1'b0};
  localparam logic [7:0] CD [4] = '{ALM_WELDED, ALM_MAIN_CIRC, ALM_OPEN_PHASE, ALM_GND_FAULT};
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic pwr = 1'b0, est = 1'b0, sof = 1'b0, stp = 1'b0, dc1 = 1'b1, typ = 1'b1;
  logic [2:0] pat = 3'b111, weld = 3'b000;
  int fail_count = 0, cmp_count = 0, k;
  wire c1, con, brk, ext1, dec, drop, c2, ext2, uv2, mon, alm, uv1;
  wire [7:0] code1, code2;
  wire [4:0] w;
  drive_link_if link1 ();
  drive_link_if link2 ();
  // 100 MHz system clock
  always #5 ref_clk_i = ~ref_clk_i;
  // Lines the bounded waits can watch
  assign w = {ext2, link1.alarm, c2, link1.motor_on, c1};

  // Phases follow the contactor; weld is what shows while it is open
  supply_unit #(.CHECK_CYC(20), .FORCE_CYC(1000)) supply_unit_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link1.supply),
    .mains_phase_inputs_i(c1 ? pat : weld), .supply_type_param_i(typ),
    .dc_bus_ok_i(dc1), .motor_stopped_i(stp), .contactor_drive_out_o(c1),
    .external_estop_signal_o(ext1), .brake_release_out_o(brk), .decel_active_o(dec),
    .drop_prevent_o(drop), .undervoltage_o(uv1), .alarm_code_o(code1));
  nc_controller nc_controller_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link1.ctrl), .power_req_i(pwr),
    .estop_req_i(est), .servo_off_req_i(sof), .contactor_on_o(con), .motor_on_o(mon),
    .alarm_o(alm));
  // Second supply end faces the bench, which plays a controller that shuts off only in the cancel case;
  // it shares the phase, type and stop lines, which sit at their idle values then
  supply_unit #(.CHECK_CYC(20), .FORCE_CYC(50)) supply_unit_inst2 (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .link(link2.supply),
    .mains_phase_inputs_i(c2 ? pat : weld), .supply_type_param_i(typ),
    .dc_bus_ok_i(dc1), .motor_stopped_i(stp), .contactor_drive_out_o(c2),
    .external_estop_signal_o(ext2), .brake_release_out_o(), .decel_active_o(),
    .drop_prevent_o(), .undervoltage_o(uv2), .alarm_code_o(code2));
  link_check link_check_inst (
    .ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .ready_on(link1.ready_on),
    .estop(link1.estop), .servo_off(link1.servo_off), .shutoff_cmd(link1.shutoff_cmd),
    .zero_speed(link1.zero_speed), .motor_on(link1.motor_on),
    .contactor_on(link1.contactor_on), .alarm(link1.alarm));

  // --------------------------------------------------------------
  // Shared tasks
  // --------------------------------------------------------------
  task finish_test();
    $display("Compares %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : finish_test
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task cyc(input int n);
    repeat (n) @(negedge ref_clk_i);
  endtask : cyc
  // Bounded wait; k returns the cycles it took, running out ends the run
  task wt(input int b, input logic v, input int n);
    k = 0;
    while (w[b] !== v) begin
      if (k == n) begin
        fail_count++;
        $display("FAIL %0t: wait on line %0d ran out", $time, b);
        finish_test();
      end
      k++;
      cyc(1);
    end
  endtask : wt
  task rst();
    {pwr, est, sof, stp} = '0;
    {link2.ready_on, link2.estop, link2.servo_off, link2.shutoff_cmd} = '0;
    rstn_i = 1'b0;
    cyc(12);
    rstn_i = 1'b1;
    cyc(3);
  endtask : rst
  // Brake stays applied until the motor is on, and the check waits its full delay
  task power1();
    rst();
    pwr = 1'b1;
    wt(0, 1'b1, 60);
    chk(brk, 1'b0);
    wt(1, 1'b1, 200);
    chk(k >= 20, 1'b1);
    cyc(2);
    chk(brk, 1'b1);
    chk(mon, 1'b1);
    chk(con, 1'b1);
    chk(code1, ALM_NONE);
  endtask : power1

  // --------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------
  // Without the supply type the contactor must stay open
  task t_type();
    rst();
    typ = 1'b0;
    pwr = 1'b1;
    cyc(30);
    chk(c1, 1'b0);
    typ = 1'b1;
    wt(0, 1'b1, 60);
    chk(code1, ALM_NONE);
    $display("supply type test done");
  endtask : t_type
  task t_servo_off();
    power1();
    sof = 1'b1;
    wt(1, 1'b0, 20);
    chk(brk, 1'b0);
    chk(drop, 1'b0);
    $display("servo off test done");
  endtask : t_servo_off
  task t_estop();
    power1();
    est = 1'b1;
    cyc(10);
    chk(dec, 1'b1);
    chk(drop, 1'b1);
    chk(brk, 1'b0);
    cyc(30);
    chk(c1, 1'b1);
    stp = 1'b1;
    wt(0, 1'b0, 30);
    chk(ext1, 1'b0);
    chk(uv1, 1'b0);
    $display("estop test done");
  endtask : t_estop
  task t_alarms();
    for (int i = 0; i < 4; i++) begin
      rst();
      weld = WL[i];
      pat = PT[i];
      dc1 = DC[i];
      pwr = 1'b1;
      wt(3, 1'b1, 100);
      cyc(4);
      chk(code1, CD[i]);
      chk(c1, 1'b0);
      chk(alm, 1'b1);
    end
    weld = 3'b000;
    pat = 3'b111;
    dc1 = 1'b1;
    $display("alarm test done");
  endtask : t_alarms
  task t_forced(input logic cancel);
    rst();
    link2.ready_on = 1'b1;
    wt(2, 1'b1, 60);
    cyc(30);
    link2.estop = 1'b1;
    if (cancel) begin
      cyc(20);
      link2.shutoff_cmd = 1'b1;
      cyc(1);
      link2.shutoff_cmd = 1'b0;
      wt(2, 1'b0, 5);
      cyc(60);
      chk(ext2, 1'b0);
      chk(code2, ALM_NONE);
    end else begin
      wt(2, 1'b0, 100);
      chk(k >= 50 && k <= 56, 1'b1);
      cyc(2);
      chk(ext2, 1'b1);
      chk(code2, ALM_ESTOP_ERR);
      chk(uv2, 1'b1);
    end
    $display("forced shutoff test done");
  endtask : t_forced

  initial begin
    t_type();
    t_servo_off();
    t_estop();
    t_alarms();
    t_forced(1'b0);
    t_forced(1'b1);
    finish_test();
  end
endmodule : tb
